// ### logic/tsps_top.sv
// Timing signal pin selector with AHB-Lite register slave
// Operation
// - Polarity bit per pin, 1 means active low
// - Drive-mode bit: always drive or only asserted
// - Pin control bit 2 enables pin 0
// - Register pin1_drive_enable_reg bit 6 enables pin 1
// - Select fields bits 12:8 and 4:0
// - Any signal routable to either or both
// - Select all zero gives legacy pin behaviour
// - Code 0x01 gives masked interrupt output
// - Code 0x02 spans first to last slot
// - Single slot window spans that slot only
// - Codes 0x05-0x07 copy LED pulses
// - Codes 0x0C-0x0E show data written
// - Data written set slot end, cleared sample start
// - Code 0x0F toggles once per sample
// - Half-rate starts low after entering normal
// - Code 0x10 holds logic zero
// - Code 0x11 holds logic one
// - Code 0x13 copies 32 kHz oscillator
// - Mask bits 5 and 6 mask slot interrupts when set
//
// The AHB-Lite register port was chosen for this implementation.
module tsps_top
	import tsps_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic osc32k,
	input wire logic led_pulse_a,
	input wire logic led_pulse_b,
	input wire logic slot_a_active,
	input wire logic slot_b_active,
	input wire logic slot_a_en,
	input wire logic slot_b_en,
	input wire logic normal_mode,
	input wire logic sample_int_a,
	input wire logic sample_int_b,
	input wire logic legacy_photodiode_serial_out,
	output logic timing_pin_zero_out,
	output logic timing_pin_zero_oe,
	output logic timing_pin_one_out,
	output logic timing_pin_one_oe
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [15:0] int_mask; // Interrupt mask register
		logic [15:0] pin_ctrl; // Timing pin control register
		logic [15:0] sel; // Timing signal select register
		logic [15:0] pin1_en; // Pin 1 drive enable register
		logic [31:0] rdata; // Read data for the data phase
		logic rdy; // Bus ready
		logic resp; // Bus response, always OKAY
		logic wr_pend; // Write data phase pending
		logic [7:0] wr_idx; // Index of pending write
		logic a_prev; // Slot A level, last cycle
		logic b_prev; // Slot B level, last cycle
		logic norm_prev; // Normal mode, last cycle
		logic win; // Sample window
		logic wr_a; // Slot A data written
		logic wr_b; // Slot B data written
		logic half; // Half-rate square wave
		logic p0_out; // Pin 0 level
		logic p0_oe; // Pin 0 enable
		logic p1_out; // Pin 1 level
		logic p1_oe; // Pin 1 enable
	} tsps_st_t;

	tsps_st_t st_q;
	tsps_st_t st_d;

	// ==========================================================
	// Pin input synchronisation
	logic [TSPS_SYNC_W-1:0] sync_v; // Filtered asynchronous inputs
	logic osc_s; // Oscillator copy
	logic led_a_s; // Slot A LED pulses
	logic led_b_s; // Slot B LED pulses
	logic a_act_s; // Slot A running
	logic b_act_s; // Slot B running

	tsps_sync #(
		.W(TSPS_SYNC_W)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({osc32k, led_pulse_a, led_pulse_b, slot_a_active, slot_b_active}),
		.sync_out(sync_v)
	);

	assign {osc_s, led_a_s, led_b_s, a_act_s, b_act_s} = sync_v;

	// ==========================================================
	// Slot and sample events
	logic start_a; // Slot A begins
	logic end_a; // Slot A ends
	logic start_b; // Slot B begins
	logic end_b; // Slot B ends
	logic win_start; // First enabled slot begins
	logic win_end; // Last enabled slot ends
	logic norm_rise; // Standby to normal
	logic irq_c; // Masked interrupt output

	// Edges of the synchronised slot levels
	always_comb
	begin
		start_a = a_act_s & ~st_q.a_prev;
		end_a = ~a_act_s & st_q.a_prev;
		start_b = b_act_s & ~st_q.b_prev;
		end_b = ~b_act_s & st_q.b_prev;
		win_start = (slot_a_en & start_a) | (~slot_a_en & slot_b_en & start_b);
		win_end = (slot_b_en & end_b) | (~slot_b_en & slot_a_en & end_a);
		norm_rise = normal_mode & ~st_q.norm_prev;
		irq_c = (sample_int_a & ~st_q.int_mask[TSPS_MASK_A_BIT])
			| (sample_int_b & ~st_q.int_mask[TSPS_MASK_B_BIT]);
	end

	// ==========================================================
	// Pin drivers, one per pin, sharing every source except the legacy one
	logic legacy; // Whole select register is zero
	logic p0_level; // Pin 0 next level
	logic p0_en; // Pin 0 next enable
	logic p1_level; // Pin 1 next level
	logic p1_en; // Pin 1 next enable

	assign legacy = (st_q.sel == 16'h0000);

	tsps_pin_drv u_pin0 (
		.code(st_q.sel[TSPS_SEL0_LSB +: TSPS_SEL_W]),
		.legacy(legacy),
		.legacy_sig(irq_c),
		.pol(st_q.pin_ctrl[TSPS_POL0_BIT]),
		.od(st_q.pin_ctrl[TSPS_OD0_BIT]),
		.en(st_q.pin_ctrl[TSPS_EN0_BIT]),
		.irq(irq_c),
		.win(st_q.win),
		.led_a(led_a_s),
		.led_b(led_b_s),
		.wr_a(st_q.wr_a),
		.wr_b(st_q.wr_b),
		.half(st_q.half),
		.osc(osc_s),
		.level(p0_level),
		.oe(p0_en)
	);

	tsps_pin_drv u_pin1 (
		.code(st_q.sel[TSPS_SEL1_LSB +: TSPS_SEL_W]),
		.legacy(legacy),
		.legacy_sig(legacy_photodiode_serial_out),
		.pol(st_q.pin_ctrl[TSPS_POL1_BIT]),
		.od(st_q.pin_ctrl[TSPS_OD1_BIT]),
		.en(st_q.pin1_en[TSPS_EN1_BIT]),
		.irq(irq_c),
		.win(st_q.win),
		.led_a(led_a_s),
		.led_b(led_b_s),
		.wr_a(st_q.wr_a),
		.wr_b(st_q.wr_b),
		.half(st_q.half),
		.osc(osc_s),
		.level(p1_level),
		.oe(p1_en)
	);

	// ==========================================================
	// Bus decode
	logic accept; // Address phase taken
	logic [7:0] idx; // Register index of the address phase

	assign accept = hsel & hready & htrans[1];
	assign idx = haddr[9:2];

	// Read multiplexer over the registers after any pending write
	function automatic logic [31:0] read_mux(input tsps_st_t s, input logic [7:0] i);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (i)
			TSPS_IDX_INT_MASK: r = {16'h0000, s.int_mask};
			TSPS_IDX_PIN_CTRL: r = {16'h0000, s.pin_ctrl};
			TSPS_IDX_SEL: r = {16'h0000, s.sel};
			TSPS_IDX_PIN1_EN: r = {16'h0000, s.pin1_en};
			TSPS_IDX_STATE: r = {24'h00_0000, s.p1_oe, s.p1_out, s.p0_oe, s.p0_out,
				s.half, s.wr_b, s.wr_a, s.win};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Next state
	always_comb
	begin
		st_d = st_q;
		st_d.rdy = 1'b1;
		st_d.resp = 1'b0;
		// Data phase of a write
		if (st_q.wr_pend)
		begin
			case (st_q.wr_idx)
				TSPS_IDX_INT_MASK: st_d.int_mask = hwdata[15:0];
				TSPS_IDX_PIN_CTRL: st_d.pin_ctrl = hwdata[15:0];
				TSPS_IDX_SEL: st_d.sel = hwdata[15:0];
				TSPS_IDX_PIN1_EN: st_d.pin1_en = hwdata[15:0];
				default: st_d.int_mask = st_q.int_mask;
			endcase
		end
		// Address phase
		st_d.wr_pend = accept & hwrite;
		st_d.wr_idx = idx;
		if (accept & ~hwrite)
			st_d.rdata = read_mux(st_d, idx);
		// Slot edge history
		st_d.a_prev = a_act_s;
		st_d.b_prev = b_act_s;
		st_d.norm_prev = normal_mode;
		// Sample window
		if (win_start)
			st_d.win = 1'b1;
		else if (win_end)
			st_d.win = 1'b0;
		// Data written flags, set wins over clear
		if (end_a & slot_a_en)
			st_d.wr_a = 1'b1;
		else if (win_start)
			st_d.wr_a = 1'b0;
		if (end_b & slot_b_en)
			st_d.wr_b = 1'b1;
		else if (win_start)
			st_d.wr_b = 1'b0;
		// Half-rate wave
		if (norm_rise)
			st_d.half = 1'b0;
		else if (win_end)
			st_d.half = ~st_q.half;
		// Registered pins
		st_d.p0_out = p0_level;
		st_d.p0_oe = p0_en;
		st_d.p1_out = p1_level;
		st_d.p1_oe = p1_en;
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= '0;
			st_q.int_mask <= TSPS_RST_INT_MASK;
			st_q.pin_ctrl <= TSPS_RST_PIN_CTRL;
			st_q.sel <= TSPS_RST_SEL;
			st_q.pin1_en <= TSPS_RST_PIN1_EN;
			st_q.rdy <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// ==========================================================
	// Outputs
	assign hreadyout = st_q.rdy;
	assign hresp = st_q.resp;
	assign hrdata = st_q.rdata;
	assign timing_pin_zero_out = st_q.p0_out;
	assign timing_pin_zero_oe = st_q.p0_oe;
	assign timing_pin_one_out = st_q.p1_out;
	assign timing_pin_one_oe = st_q.p1_oe;

	// ==========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [4:0] code0; // Pin 0 select field
	logic [4:0] code1; // Pin 1 select field
	assign code0 = st_q.sel[4:0];
	assign code1 = st_q.sel[12:8];

	// Last enabled slot has just finished
	sequence s_sample_done;
		win_end && !norm_rise;
	endsequence

	a_pin0_off: assert property (!st_q.pin_ctrl[2] |=> !timing_pin_zero_oe)
		else $error("pin 0 drives while disabled");
	a_pin1_off: assert property (!st_q.pin1_en[6] |=> !timing_pin_one_oe)
		else $error("pin 1 drives while disabled");
	a_const_low: assert property (code0 == 5'h10
		|=> timing_pin_zero_out == $past(st_q.pin_ctrl[0]))
		else $error("constant low wrong on pin 0");
	a_const_high: assert property (code1 == 5'h11
		|=> timing_pin_one_out == !$past(st_q.pin_ctrl[8]))
		else $error("constant high wrong on pin 1");
	a_od_release: assert property (code0 == 5'h10 && st_q.pin_ctrl[1] |=> !timing_pin_zero_oe)
		else $error("open drain pin drives while idle");
	a_push_pull: assert property (code0 == 5'h10 && st_q.pin_ctrl[2:1] == 2'b10
		|=> timing_pin_zero_oe)
		else $error("push pull pin not driving");
	a_legacy_int: assert property (legacy && !st_q.pin_ctrl[0]
		|=> timing_pin_zero_out == $past(irq_c))
		else $error("legacy pin 0 not interrupt");
	a_mask_a: assert property (sample_int_a && !st_q.int_mask[5] |-> irq_c)
		else $error("slot A interrupt not unmasked");
	a_window_rise: assert property ($rose(st_q.win) |-> $past(win_start))
		else $error("window rose without slot start");
	a_written_clear: assert property (win_start && !(end_a && slot_a_en) |=> !st_q.wr_a)
		else $error("data written not cleared at sample start");
	a_half_start: assert property (norm_rise |=> !st_q.half)
		else $error("half rate not low after entering normal");
	a_half_toggle: assert property (s_sample_done |=> st_q.half != $past(st_q.half))
		else $error("half rate did not toggle");
	a_undef_idle: assert property (code1 == 5'h03 && !legacy
		|=> timing_pin_one_out == $past(st_q.pin_ctrl[8]))
		else $error("undefined code not inactive");
	a_mask_b: assert property (sample_int_b && !st_q.int_mask[6] |-> irq_c)
		else $error("slot B interrupt not unmasked");
	a_int_route: assert property (code1 == 5'h01 && !st_q.pin_ctrl[8]
		|=> timing_pin_one_out == $past(irq_c))
		else $error("interrupt not routed to pin 1");
	a_legacy_pin1: assert property (legacy && !st_q.pin_ctrl[8]
		|=> timing_pin_one_out == $past(legacy_photodiode_serial_out))
		else $error("legacy pin 1 not serial output");
	a_led_both: assert property (code0 == 5'h07 && !st_q.pin_ctrl[0]
		|=> timing_pin_zero_out == ($past(led_a_s) | $past(led_b_s)))
		else $error("pin 0 not showing both LED pulses");
	a_osc_copy: assert property (code0 == 5'h13 && !st_q.pin_ctrl[0]
		|=> timing_pin_zero_out == $past(osc_s))
		else $error("pin 0 not copying oscillator");
	a_window_fall: assert property ($fell(st_q.win) |-> $past(win_end))
		else $error("window fell without last slot end");
	a_written_set_a: assert property (end_a && slot_a_en |=> st_q.wr_a)
		else $error("slot A data written not set");
	a_written_set_b: assert property (end_b && slot_b_en |=> st_q.wr_b)
		else $error("slot B data written not set");

	// Only slot A enabled and it has just ended
	sequence s_single_end;
		slot_a_en && !slot_b_en && end_a;
	endsequence

	a_single_slot: assert property (s_single_end |=> !st_q.win)
		else $error("single slot window still open");

endmodule

// ### pkg/tsps_pkg.sv
// Constants shared by the timing signal pin selector
package tsps_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] TSPS_IDX_INT_MASK = 8'h01; // Interrupt mask
	localparam logic [7:0] TSPS_IDX_PIN_CTRL = 8'h02; // Pin polarity, drive mode, pin 0 enable
	localparam logic [7:0] TSPS_IDX_SEL = 8'h0B; // Signal source select for both pins
	localparam logic [7:0] TSPS_IDX_PIN1_EN = 8'h4F; // Holds pin 1 drive enable
	localparam logic [7:0] TSPS_IDX_STATE = 8'h50; // Read-only block state

	// ==========================================================
	// Values after reset
	localparam logic [15:0] TSPS_RST_INT_MASK = 16'h0000;
	localparam logic [15:0] TSPS_RST_PIN_CTRL = 16'h0000;
	localparam logic [15:0] TSPS_RST_SEL = 16'h0000;
	localparam logic [15:0] TSPS_RST_PIN1_EN = 16'h0000;

	// ==========================================================
	// Field positions
	localparam int TSPS_POL0_BIT = 0; // Pin 0 polarity
	localparam int TSPS_OD0_BIT = 1; // Pin 0 drive mode
	localparam int TSPS_EN0_BIT = 2; // Pin 0 drive enable
	localparam int TSPS_POL1_BIT = 8; // Pin 1 polarity
	localparam int TSPS_OD1_BIT = 9; // Pin 1 drive mode
	localparam int TSPS_EN1_BIT = 6; // Pin 1 drive enable
	localparam int TSPS_MASK_A_BIT = 5; // Slot A sample interrupt mask
	localparam int TSPS_MASK_B_BIT = 6; // Slot B sample interrupt mask
	localparam int TSPS_SEL0_LSB = 0; // Pin 0 select field low bit
	localparam int TSPS_SEL1_LSB = 8; // Pin 1 select field low bit
	localparam int TSPS_SEL_W = 5; // Select field width

	// ==========================================================
	// Select codes
	localparam logic [4:0] TSPS_CODE_INT = 5'h01;
	localparam logic [4:0] TSPS_CODE_WIN = 5'h02;
	localparam logic [4:0] TSPS_CODE_LED_A = 5'h05;
	localparam logic [4:0] TSPS_CODE_LED_B = 5'h06;
	localparam logic [4:0] TSPS_CODE_LED_AB = 5'h07;
	localparam logic [4:0] TSPS_CODE_WR_A = 5'h0C;
	localparam logic [4:0] TSPS_CODE_WR_B = 5'h0D;
	localparam logic [4:0] TSPS_CODE_WR_AB = 5'h0E;
	localparam logic [4:0] TSPS_CODE_HALF = 5'h0F;
	localparam logic [4:0] TSPS_CODE_LOW = 5'h10;
	localparam logic [4:0] TSPS_CODE_HIGH = 5'h11;
	localparam logic [4:0] TSPS_CODE_OSC = 5'h13;

	// ==========================================================
	// Synchroniser width: oscillator, two LED pulses, two slot levels
	localparam int TSPS_SYNC_W = 5;

endpackage

// ### logic/tsps_sync.sv
// Three-stage input synchroniser with agreement filter
module tsps_sync
	import tsps_pkg::*;
#(
	parameter int W = 1
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [W-1:0] ff1; // Metastable stage, read only by ff2
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] out; // Filtered level
	} tsps_sync_st_t;

	tsps_sync_st_t st_q;
	tsps_sync_st_t st_d;

	// Shift chain; a change counts once stages two and three agree
	always_comb
	begin
		st_d = st_q;
		st_d.ff1 = async_in;
		st_d.ff2 = st_q.ff1;
		st_d.ff3 = st_q.ff2;
		for (int i = 0; i < W; i++)
		begin
			if (st_q.ff2[i] == st_q.ff3[i])
			begin
				st_d.out[i] = st_q.ff3[i];
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.out;

endmodule

// ### logic/tsps_pin_drv.sv
// Source select, polarity and drive mode for one timing pin
module tsps_pin_drv
	import tsps_pkg::*;
(
	input wire logic [4:0] code,
	input wire logic legacy,
	input wire logic legacy_sig,
	input wire logic pol,
	input wire logic od,
	input wire logic en,
	input wire logic irq,
	input wire logic win,
	input wire logic led_a,
	input wire logic led_b,
	input wire logic wr_a,
	input wire logic wr_b,
	input wire logic half,
	input wire logic osc,
	output logic level,
	output logic oe
);

	logic asserted; // Selected signal before polarity

	// Source multiplexer
	always_comb
	begin
		if (legacy)
			asserted = legacy_sig;
		else
		begin
			case (code)
				TSPS_CODE_INT: asserted = irq;
				TSPS_CODE_WIN: asserted = win;
				TSPS_CODE_LED_A: asserted = led_a;
				TSPS_CODE_LED_B: asserted = led_b;
				TSPS_CODE_LED_AB: asserted = led_a | led_b;
				TSPS_CODE_WR_A: asserted = wr_a;
				TSPS_CODE_WR_B: asserted = wr_b;
				TSPS_CODE_WR_AB: asserted = wr_a | wr_b;
				TSPS_CODE_HALF: asserted = half;
				TSPS_CODE_LOW: asserted = 1'b0;
				TSPS_CODE_HIGH: asserted = 1'b1;
				TSPS_CODE_OSC: asserted = osc;
				default: asserted = 1'b0;
			endcase
		end
	end

	// Polarity and drive enable
	always_comb
	begin
		level = asserted ^ pol;
		oe = en & (~od | asserted);
	end

endmodule

// ### verif/tsps_far_end.sv
// Far-side model: shared pin lines with pull-up
module tsps_far_end
(
	input wire logic p0_out,
	input wire logic p0_oe,
	input wire logic p1_out,
	input wire logic p1_oe,
	output logic p0_wire,
	output logic p1_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Released line rises to the pull-up level
	assign p0_wire = p0_oe ? p0_out : 1'b1;
	assign p1_wire = p1_oe ? p1_out : 1'b1;
endmodule

// ### verif/test_timing_signal_pin_selector.sv
// Self-checking bench for the timing signal pin selector
module test_timing_signal_pin_selector
	import tsps_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Bus and source signals
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r, r2;
	logic [1:0] htrans = 2'h0;
	logic osc = 0, la = 0, lb = 0, sa = 0, sb = 0, ea = 0, eb = 0;
	logic nm = 0, ia = 0, ib = 0, leg = 0;
	logic [1:0] po, poe, w; // Pin level, enable, wire
	logic [15:0] m, pc, pe, sel; // Register mirrors
	logic [4:0] c0, c1;
	logic [31:0] seed = 32'h9F70;
	int fails = 0;
	int check_count = 0;
	// Static codes plus two undefined ones
	logic [4:0] codes [10] = '{5'h00, TSPS_CODE_INT, TSPS_CODE_LED_A, TSPS_CODE_LED_B,
		TSPS_CODE_LED_AB, TSPS_CODE_LOW, TSPS_CODE_HIGH, TSPS_CODE_OSC, 5'h03, 5'h1F};

	// Clock of 40 ns period
	always #20 hclk = ~hclk;

	tsps_top u_tsps_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.osc32k(osc), .led_pulse_a(la), .led_pulse_b(lb), .slot_a_active(sa),
		.slot_b_active(sb), .slot_a_en(ea), .slot_b_en(eb), .normal_mode(nm),
		.sample_int_a(ia), .sample_int_b(ib), .legacy_photodiode_serial_out(leg),
		.timing_pin_zero_out(po[0]), .timing_pin_zero_oe(poe[0]),
		.timing_pin_one_out(po[1]), .timing_pin_one_oe(poe[1]));

	tsps_far_end u_tsps_far_end (.p0_out(po[0]), .p0_oe(poe[0]), .p1_out(po[1]),
		.p1_oe(poe[1]), .p0_wire(w[0]), .p1_wire(w[1]));

	// ==========
	// Reporting
	task give_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask

	// Xorshift source, fixed seed
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// ==========
	// AHB-Lite single transfers
	task wait_rdy();
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1)
		begin
			fails++;
			give_verdict();
		end
	endtask

	task ahb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'hA5A5, d};
		wait_rdy();
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task setsel(input logic [15:0] v);
		sel = v;
		ahb(1'b1, TSPS_IDX_SEL, v);
		repeat (3) @(posedge hclk);
	endtask

	// ==========
	// Expected asserted state of a pin source
	function automatic logic src(input logic [4:0] c, input logic one);
		logic irq;
		irq = (ia & ~m[TSPS_MASK_A_BIT]) | (ib & ~m[TSPS_MASK_B_BIT]);
		if (sel === 16'h0)
			return one ? leg : irq;
		case (c)
			TSPS_CODE_INT: return irq;
			TSPS_CODE_LED_A: return la;
			TSPS_CODE_LED_B: return lb;
			TSPS_CODE_LED_AB: return la | lb;
			TSPS_CODE_HIGH: return 1'b1;
			TSPS_CODE_OSC: return osc;
			default: return 1'b0;
		endcase
	endfunction

	// Compare both pins against their asserted state
	task pins(input logic a0, input logic a1);
		logic lv;
		logic oe;
		lv = a0 ^ pc[TSPS_POL0_BIT];
		oe = pc[TSPS_EN0_BIT] & (a0 | ~pc[TSPS_OD0_BIT]);
		chk("p0_out", po[0], lv);
		chk("p0_oe", poe[0], oe);
		chk("p0_wire", w[0], oe ? lv : 1'b1);
		lv = a1 ^ pc[TSPS_POL1_BIT];
		oe = pe[TSPS_EN1_BIT] & (a1 | ~pc[TSPS_OD1_BIT]);
		chk("p1_out", po[1], lv);
		chk("p1_oe", poe[1], oe);
		chk("p1_wire", w[1], oe ? lv : 1'b1);
	endtask

	// Run one slot edge and let it settle
	task slot(input logic b, input logic v);
		@(posedge hclk);
		if (b)
			sb <= v;
		else
			sa <= v;
		repeat (8) @(posedge hclk);
	endtask

	// ==========
	// Main sequence
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values and an unmapped place
		foreach (codes[i])
		begin
			r = {24'h0, i == 0 ? TSPS_IDX_INT_MASK : i == 1 ? TSPS_IDX_PIN_CTRL :
				i == 2 ? TSPS_IDX_SEL : i == 3 ? TSPS_IDX_PIN1_EN : 8'h30};
			ahb(1'b0, r[7:0], 16'h0);
			chk("reset", rd, 32'h0);
		end
		ahb(1'b1, 8'h30, 16'hFFFF);
		ahb(1'b0, 8'h30, 16'h0);
		chk("unmapped", rd, 32'h0);
		// Random static sources, codes and pin settings
		for (int n = 0; n < 40; n++)
		begin
			r = rnd();
			r2 = rnd();
			c0 = codes[r2[3:0] % 10];
			c1 = r2[8] ? c0 : codes[r2[7:4] % 10];
			m = r[15:0];
			pc = r[31:16];
			pe = r2[31:16];
			{osc, la, lb, ia, ib, leg} <= r2[14:9];
			ahb(1'b1, TSPS_IDX_INT_MASK, m);
			ahb(1'b1, TSPS_IDX_PIN_CTRL, pc);
			ahb(1'b1, TSPS_IDX_PIN1_EN, pe);
			setsel({3'h0, c1, 3'h0, c0});
			repeat (5) @(posedge hclk);
			pins(src(c0, 1'b0), src(c1, 1'b1));
			ahb(1'b0, TSPS_IDX_SEL, 16'h0);
			chk("sel", rd, {16'h0, sel});
		end
		// Window, data-written and half-rate over samples
		pc = 16'h0004;
		pe = 16'h0040;
		ahb(1'b1, TSPS_IDX_PIN_CTRL, pc);
		ahb(1'b1, TSPS_IDX_PIN1_EN, pe);
		ea <= 1'b1;
		eb <= 1'b1;
		nm <= 1'b1;
		setsel({3'h0, TSPS_CODE_HALF, 3'h0, TSPS_CODE_WIN});
		pins(1'b0, 1'b0);
		slot(1'b0, 1'b1);
		pins(1'b1, 1'b0);
		slot(1'b0, 1'b0);
		pins(1'b1, 1'b0);
		slot(1'b1, 1'b1);
		slot(1'b1, 1'b0);
		pins(1'b0, 1'b1);
		ahb(1'b0, TSPS_IDX_STATE, 16'h0);
		chk("state", rd, 32'h0000_00EE);
		setsel({3'h0, TSPS_CODE_WR_AB, 3'h0, TSPS_CODE_WR_A});
		pins(1'b1, 1'b1);
		slot(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		slot(1'b0, 1'b0);
		pins(1'b1, 1'b1);
		setsel({3'h0, TSPS_CODE_WR_B, 3'h0, TSPS_CODE_WR_A});
		pins(1'b1, 1'b0);
		slot(1'b1, 1'b1);
		slot(1'b1, 1'b0);
		pins(1'b1, 1'b1);
		setsel({3'h0, TSPS_CODE_HALF, 3'h0, TSPS_CODE_WIN});
		pins(1'b0, 1'b0);
		// Single enabled slot
		eb <= 1'b0;
		slot(1'b0, 1'b1);
		pins(1'b1, 1'b0);
		slot(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		// Leaving and re-entering normal operation
		nm <= 1'b0;
		repeat (3) @(posedge hclk);
		nm <= 1'b1;
		repeat (3) @(posedge hclk);
		pins(1'b0, 1'b0);
		give_verdict();
	end
endmodule
